// ==== src/hbh_buffer_handshake.sv ====
// HDLC buffer handshake: receive fill engine, transmit drain engine and
// the shared RAM window seen by the host. Host port, deframer and framer
// are all synchronous to core_clk.
`default_nettype none
`include "hbh_consts.svh"

module hbh_buffer_handshake (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Host shared RAM port
  input  wire logic [5:0] hostAddr,
  input  wire logic       hostWrEn,
  input  wire logic [7:0] hostWrData,
  input  wire logic       hostRdEn,
  output logic      [7:0] hostRdData,
  // Deframer stream in
  input  wire logic       rxInValid,
  input  wire logic [7:0] rxInData,
  input  wire logic       rxInStart,
  input  wire logic       rxInEnd,
  input  wire logic [1:0] rxInErr,
  output logic            rxInReady,
  // Framer stream out
  output logic            txOutValid,
  output logic      [7:0] txOutData,
  output logic            txOutStart,
  output logic            txOutEnd,
  output logic            txOutAbort,
  input  wire logic       txOutReady,
  // Buffer events
  output logic            rx_buffer_full_irq,
  output logic            tx_buffer_empty_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0][7:0]      rxMem;
    logic [15:0][7:0]      txMem;
    logic [1:0][7:0]       rxStat;
    logic [1:0][7:0]       txStat;
    logic [7:0]            system_error_word;
    logic                  txRun;
    hbh_pkg::hbh_rx_state_t rxState;
    logic                  rxBuf;
    logic [3:0]            rxCnt;
    logic                  rxSfrm;
    hbh_pkg::hbh_tx_state_t txState;
    logic                  txBuf;
    logic [3:0]            txIdx;
    logic                  txValid;
    logic [7:0]            txData;
    logic                  txFirst;
    logic                  txLast;
    logic                  txAbort;
    logic [7:0]            rdData;
    logic                  rxIrq;
    logic                  txIrq;
  } hbh_state_t;

  hbh_state_t            q;
  hbh_state_t            d;
  hbh_pkg::hbh_rx_entry_t inEntry;
  hbh_pkg::hbh_rx_entry_t fifoEntry;
  logic                  fifoValid;
  logic                  fifoPop;

  // ****************************************
  // Receive FIFO between deframer and buffers
  // ****************************************
  assign inEntry = '{frameEnd: rxInEnd, frameStart: rxInStart, errKind: rxInErr,
                     data: rxInData};
  assign fifoPop = (q.rxState == hbh_pkg::RX_FILL);

  hbh_fifo #(
    .WIDTH ($bits(hbh_pkg::hbh_rx_entry_t)),
    .DEPTH (`HBH_FIFO_DEPTH)
  ) rxFifo (
    .clk      (core_clk),
    .rst      (rst),
    .inValid  (rxInValid),
    .inData   (inEntry),
    .inReady  (rxInReady),
    .outValid (fifoValid),
    .outData  (fifoEntry),
    .outReady (fifoPop)
  );

  // Outputs straight from flops
  assign hostRdData          = q.rdData;
  assign txOutValid          = q.txValid;
  assign txOutData           = q.txData;
  assign txOutStart          = q.txFirst;
  assign txOutEnd            = q.txLast;
  assign txOutAbort          = q.txAbort;
  assign rx_buffer_full_irq  = q.rxIrq;
  assign tx_buffer_empty_irq = q.txIrq;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [7:0] txSt;
    logic [3:0] txLen;
    logic [3:0] nextCnt;
    logic       effStart;
    txSt     = q.txStat[q.txBuf];
    txLen    = (txSt[`HBH_LEN_MSB:`HBH_LEN_LSB] == 4'h0) ? 4'h1 : txSt[`HBH_LEN_MSB:`HBH_LEN_LSB];
    nextCnt  = q.rxCnt + 4'h1;
    effStart = (q.rxCnt == 4'h0) ? fifoEntry.frameStart : q.rxSfrm;
    d        = q;
    d.rxIrq  = 1'b0;
    d.txIrq  = 1'b0;

    // Host read mux, one cycle of latency
    if (hostRdEn)
    begin
      if (hostAddr < `HBH_TX_BUF_BASE)
        d.rdData = q.rxMem[hostAddr[3:0]];
      else if (hostAddr < `HBH_RX_STAT0)
        d.rdData = q.txMem[hostAddr[3:0]];
      else
        case (hostAddr)
          `HBH_RX_STAT0: d.rdData = q.rxStat[0];
          `HBH_RX_STAT1: d.rdData = q.rxStat[1];
          `HBH_TX_STAT0: d.rdData = q.txStat[0];
          `HBH_TX_STAT1: d.rdData = q.txStat[1];
          `HBH_CMD:      d.rdData = {7'h00, q.txRun};
          `HBH_SYS_ERR:  d.rdData = q.system_error_word;
          default:       d.rdData = 8'h00;
        endcase
    end

    // Host writes first, so device updates below win a same-cycle clash
    if (hostWrEn)
    begin
      if (hostAddr >= `HBH_TX_BUF_BASE && hostAddr < `HBH_RX_STAT0)
        d.txMem[hostAddr[3:0]] = hostWrData;
      case (hostAddr)
        `HBH_RX_STAT0: d.rxStat[0] = hostWrData;
        `HBH_RX_STAT1: d.rxStat[1] = hostWrData;
        `HBH_TX_STAT0: d.txStat[0] = hostWrData;
        `HBH_TX_STAT1: d.txStat[1] = hostWrData;
        `HBH_CMD:      d.txRun     = (hostWrData == `HBH_CMD_RUN);
        `HBH_SYS_ERR:  d.system_error_word    = q.system_error_word & ~hostWrData;   // Write one to clear
        default:       d.txRun     = d.txRun;
      endcase
    end

    // Receive fill engine
    case (q.rxState)
      hbh_pkg::RX_WAIT:
      begin
        // Availability is checked only when data is ready to be placed
        if (fifoValid)
        begin
          if (q.rxStat[q.rxBuf] == `HBH_STAT_EMPTY)
          begin
            d.rxState = hbh_pkg::RX_FILL;
            d.rxCnt   = 4'h0;
          end
          else
            d.system_error_word[`HBH_ERR_RX_BIT] = 1'b1;
        end
      end
      hbh_pkg::RX_FILL:
      begin
        if (fifoValid)
        begin
          d.rxMem[{q.rxBuf, q.rxCnt[2:0]}] = fifoEntry.data;
          d.rxSfrm = effStart;
          d.rxCnt  = nextCnt;
          if (fifoEntry.frameEnd || nextCnt == `HBH_BUF_BYTES)
          begin
            d.rxStat[q.rxBuf][`HBH_LEN_MSB:`HBH_LEN_LSB] = nextCnt;
            d.rxStat[q.rxBuf][`HBH_ERR_MSB:`HBH_ERR_LSB] =
              fifoEntry.frameEnd ? fifoEntry.errKind : 2'b00;
            d.rxStat[q.rxBuf][`HBH_RX_SFRM] = effStart;
            d.rxStat[q.rxBuf][`HBH_RX_EFRM] = fifoEntry.frameEnd;
            d.rxIrq   = 1'b1;
            d.rxBuf   = !q.rxBuf;
            d.rxState = hbh_pkg::RX_WAIT;
          end
        end
        else
          d.rxState = hbh_pkg::RX_FILL;   // Stream gap inside a buffer: hold
      end
      default: d.rxState = hbh_pkg::RX_WAIT;
    endcase

    // Transmit drain engine
    case (q.txState)
      hbh_pkg::TX_IDLE:
      begin
        // Run starts at buffer zero; TX_CHECK waits until its status is no longer empty
        if (q.txRun)
        begin
          d.txState = hbh_pkg::TX_CHECK;
          d.txBuf   = 1'b0;
        end
      end
      hbh_pkg::TX_CHECK:
      begin
        if (!q.txRun)
          d.txState = hbh_pkg::TX_IDLE;
        else if (txSt != `HBH_STAT_EMPTY)
        begin
          d.txState = hbh_pkg::TX_SEND;
          d.txIdx   = 4'h0;
        end
      end
      hbh_pkg::TX_SEND:
      begin
        if (!q.txValid || txOutReady)
        begin
          if (q.txIdx < txLen)
          begin
            d.txValid = 1'b1;
            d.txData  = txSt[`HBH_TX_FRAB] ? 8'h00 : q.txMem[{q.txBuf, q.txIdx[2:0]}];
            d.txFirst = (q.txIdx == 4'h0) && txSt[`HBH_TX_SFRM];
            d.txLast  = (q.txIdx == txLen - 4'h1) && txSt[`HBH_TX_EFRM];
            d.txAbort = (q.txIdx == txLen - 4'h1) && txSt[`HBH_TX_FRAB];
            d.txIdx   = q.txIdx + 4'h1;
          end
          else
          begin
            // Last beat accepted: hand the buffer back
            d.txValid             = 1'b0;
            d.txStat[q.txBuf]     = `HBH_STAT_EMPTY;
            d.txIrq               = 1'b1;
            d.txBuf               = !q.txBuf;
            d.txState             = hbh_pkg::TX_CHECK;
          end
        end
      end
      default: d.txState = hbh_pkg::TX_IDLE;
    endcase
  end

  // Registered state
  always_ff @(posedge core_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

endmodule

`default_nettype wire

// ==== src/hbh_consts.svh ====
// Offsets, field positions, sizes, the empty status and the command code of the
// HDLC buffer handshake block. Assumes inclusion by bare name.
`ifndef HBH_CONSTS_SVH
`define HBH_CONSTS_SVH

// ****************************************
// Shared RAM map (host byte addresses)
// ****************************************
`define HBH_ADDR_W        6
`define HBH_RX_BUF_BASE   6'h00
`define HBH_TX_BUF_BASE   6'h10
`define HBH_RX_STAT0      6'h20
`define HBH_RX_STAT1      6'h21
`define HBH_TX_STAT0      6'h22
`define HBH_TX_STAT1      6'h23
`define HBH_CMD           6'h24
`define HBH_SYS_ERR       6'h25

// ****************************************
// Status word fields
// ****************************************
`define HBH_LEN_LSB       0
`define HBH_LEN_MSB       3
`define HBH_ERR_LSB       4
`define HBH_ERR_MSB       5
`define HBH_RX_SFRM       6
`define HBH_RX_EFRM       7
`define HBH_TX_SFRM       4
`define HBH_TX_EFRM       5
`define HBH_TX_FRAB       6
`define HBH_BUF_BYTES     4'h8
`define HBH_STAT_EMPTY    8'h00

// ****************************************
// Command and error word bits, receive FIFO depth
// ****************************************
`define HBH_CMD_RUN       8'h01
`define HBH_ERR_RX_BIT    0
`define HBH_FIFO_DEPTH    16

`endif

// ==== src/hbh_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock.
`default_nettype none

module hbh_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Draining side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wrPtr;
    logic [AW:0]                 rdPtr;
  } hbh_fifo_state_t;

  hbh_fifo_state_t q;
  hbh_fifo_state_t d;
  logic            isFull;
  logic            isEmpty;

  // ****************************************
  // Flags from the extra pointer bit
  // ****************************************
  assign isEmpty  = (q.wrPtr == q.rdPtr);
  assign isFull   = (q.wrPtr[AW] != q.rdPtr[AW]) && (q.wrPtr[AW-1:0] == q.rdPtr[AW-1:0]);
  assign inReady  = !isFull;
  assign outValid = !isEmpty;
  assign outData  = q.mem[q.rdPtr[AW-1:0]];   // Memory flops, no extra stage

  // Pointer and memory update
  always_comb
  begin
    d = q;
    if (inValid && !isFull)
    begin
      d.mem[q.wrPtr[AW-1:0]] = inData;
      d.wrPtr                = q.wrPtr + 1'b1;
    end
    if (outReady && !isEmpty)
      d.rdPtr = q.rdPtr + 1'b1;
  end

  // Registered state
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

endmodule

`default_nettype wire

// ==== src/hbh_pkg.sv ====
// Types shared by the buffer handshake block and its FIFO.
// Assumes the constants header is compiled alongside.
`default_nettype none

package hbh_pkg;

  // ****************************************
  // Entry carried from the deframer to the fill engine
  // ****************************************
  typedef struct packed {
    logic       frameEnd;
    logic       frameStart;
    logic [1:0] errKind;
    logic [7:0] data;
  } hbh_rx_entry_t;

  typedef enum logic [0:0] {RX_WAIT, RX_FILL} hbh_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_CHECK, TX_SEND} hbh_tx_state_t;

endpackage

`default_nettype wire

// ==== tb/hbh_buffer_handshake_test.sv ====
// Self-checking bench: receive fill, stall with held status, transmit drain.
// Assumes the host model and the bound checker are compiled first.
`default_nettype none

module hbh_buffer_handshake_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [5:0] hostAddr;
  logic [7:0] hostWrData, hostRdData, txOutData, got;
  logic [7:0] rxInData = 8'h00;
  logic       hostWrEn, hostRdEn, rxInReady, txOutValid, txOutStart, txOutEnd, txOutAbort;
  logic       rxInValid = 1'b0, rxInStart = 1'b0, rxInEnd = 1'b0, txOutReady = 1'b0;
  logic [1:0] rxInErr = 2'h0;
  logic       rx_buffer_full_irq, tx_buffer_empty_irq, rxBuf = 1'b0;
  int         nErrors = 0, testsRun = 0, cycles = 0, rxIrqs = 0, txIrqs = 0;

  hbh_buffer_handshake DUT (.*);
  hbh_host_model host (.*);

  always #10 core_clk = ~core_clk;

  // Cuts a hang short; the whole run needs well under 3000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      nErrors++;
      giveVerdict();
    end
  end

  // Event pulses are counted mid-cycle, where the flops have settled
  always @(negedge core_clk)
  begin
    if (rx_buffer_full_irq)
      rxIrqs++;
    if (tx_buffer_empty_irq)
      txIrqs++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] seen);
    testsRun++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic giveVerdict();
    $display("Checks %0d, mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Offer one byte just after an edge and hold it until the FIFO takes it
  task automatic push(input logic [7:0] d, input logic s, input logic e, input logic [1:0] er);
    rxInValid <= 1'b1;
    rxInData <= d;
    rxInStart <= s;
    rxInEnd <= e;
    rxInErr <= er;
    // Ready is looked at mid-cycle, so the edge that takes the byte is known
    do @(negedge core_clk); while (!rxInReady);
    @(posedge core_clk);
  endtask

  // Poll the next receive status, compare it and its bytes, then free it
  task automatic take_buf(input logic [7:0] stat, input logic [7:0] first);
    got = 8'h00;
    for (int i = 0; i < 100 && got == 8'h00; i++)
      host.rd({5'h10, rxBuf}, got);
    check("rx status", stat, got);
    for (int i = 0; i < stat[3:0]; i++)
    begin
      host.rd({2'b00, rxBuf, 3'(i)}, got);
      check("rx byte", first + 8'(i), got);
    end
    host.wr({5'h10, rxBuf}, 8'h00);
    rxBuf = ~rxBuf;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Every error kind in one-byte frames, buffers alternating
  task automatic t_rx_kinds();
    host.rd(6'h20, got);
    check("empty status", 8'h00, got);
    host.rd(6'h3F, got);
    check("unmapped", 8'h00, got);
    for (int e = 0; e < 4; e++)
    begin
      @(posedge core_clk);
      push(8'h50 + 8'(e), 1'b1, 1'b1, 2'(e));
      rxInValid <= 1'b0;
      take_buf({2'b11, 2'(e), 4'h1}, 8'h50 + 8'(e));
    end
    check("rx irqs", 11'h004, 11'(rxIrqs));
    $display("Test rx kinds done");
  endtask

  // Both statuses held: fill stalls, error flags, FIFO fills to refusal
  task automatic t_rx_stall();
    int n;
    n = 0;
    @(posedge core_clk);
    push(8'h60, 1'b1, 1'b1, 2'h0);
    push(8'h61, 1'b1, 1'b1, 2'h0);
    push(8'h00, 1'b1, 1'b0, 2'h0);
    rxInStart <= 1'b0;
    rxInData <= 8'h01;
    n = 1;
    repeat (40)
    begin
      @(negedge core_clk);
      if (rxInReady)
        n++;
      @(posedge core_clk);
      rxInData <= 8'(n);
      rxInEnd <= (n == 15);
    end
    rxInValid <= 1'b0;
    check("fifo accepted", 11'd16, 11'(n));
    host.rd(6'h25, got);
    check("rx error", 8'h01, got);
    take_buf(8'hC1, 8'h60);
    take_buf(8'hC1, 8'h61);
    take_buf(8'h48, 8'h00);
    take_buf(8'h88, 8'h08);
    check("rx irqs", 11'h008, 11'(rxIrqs));
    host.wr(6'h25, 8'h01);
    host.rd(6'h25, got);
    check("rx error clear", 8'h00, got);
    $display("Test rx stall done");
  endtask

  // Data then status, command, stalled drain of buffer 0 then an abort in 1
  task automatic t_tx();
    logic [10:0] exp [4] = '{11'h1A0, 11'h0A1, 11'h2A2, 11'h400};
    int n;
    n = 0;
    for (int i = 0; i < 3; i++)
      host.wr(6'h10 + 6'(i), 8'hA0 + 8'(i));
    host.wr(6'h22, 8'h33);
    host.wr(6'h23, 8'h40);
    repeat (10) @(posedge core_clk);
    check("early beat", 1'b0, txOutValid);
    host.wr(6'h24, 8'h01);
    host.rd(6'h24, got);
    check("run flag", 8'h01, got);
    for (int c = 0; c < 200 && n < 4; c++)
    begin
      // A beat seen mid-cycle with ready up is taken at the next edge
      @(negedge core_clk);
      if (txOutValid && txOutReady)
      begin
        check("tx beat", exp[n], {txOutAbort, txOutEnd, txOutStart, txOutData});
        n++;
      end
      @(posedge core_clk);
      txOutReady <= ~txOutReady;
    end
    check("tx beats", 11'd4, 11'(n));
    host.rd(6'h22, got);
    check("tx status 0", 8'h00, got);
    host.rd(6'h23, got);
    check("tx status 1", 8'h00, got);
    check("tx irqs", 11'h002, 11'(txIrqs));
    host.wr(6'h24, 8'h00);
    $display("Test tx drain done");
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_rx_kinds();
    t_rx_stall();
    t_tx();
    giveVerdict();
  end

endmodule

`default_nettype wire

// ==== tb/hbh_checker.sv ====
// Port checker for the buffer handshake block.
// Assumes it is bound to every instance of the block's top module.
`default_nettype none

module hbh_checker (
  // Clock, reset and host port
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [5:0] hostAddr,
  input wire logic       hostWrEn,
  input wire logic [7:0] hostWrData,
  input wire logic       hostRdEn,
  input wire logic [7:0] hostRdData,
  // Streams and events
  input wire logic       rxInValid,
  input wire logic [7:0] rxInData,
  input wire logic       rxInStart,
  input wire logic       rxInEnd,
  input wire logic [1:0] rxInErr,
  input wire logic       rxInReady,
  input wire logic       txOutValid,
  input wire logic [7:0] txOutData,
  input wire logic       txOutStart,
  input wire logic       txOutEnd,
  input wire logic       txOutAbort,
  input wire logic       txOutReady,
  input wire logic       rx_buffer_full_irq,
  input wire logic       tx_buffer_empty_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Helper state and properties
  // ****************************************
  logic cmdSeen_q;

  // Remembers the first run command; a later stop may leave a beat in flight
  always_ff @(posedge core_clk)
    cmdSeen_q <= !rst && (cmdSeen_q
                 || (hostWrEn && hostAddr == 6'h24 && hostWrData == 8'h01));

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff rst;

  // A refused beat must come back with its data and abort flag unchanged
  sequence s_beatHeld;
    txOutValid && $stable(txOutData) && $stable(txOutAbort);
  endsequence

  a_tx_beat_held: assert property (txOutValid && !txOutReady |=> s_beatHeld)
    else $error("tx beat changed while stalled");
  a_tx_no_early: assert property (!cmdSeen_q |-> !txOutValid)
    else $error("tx beat before run command");
  a_rx_irq_pulse: assert property (rx_buffer_full_irq |=> !rx_buffer_full_irq)
    else $error("rx irq longer than one cycle");
  a_tx_irq_pulse: assert property (tx_buffer_empty_irq |=> !tx_buffer_empty_irq)
    else $error("tx irq longer than one cycle");
  a_tx_irq_cause: assert property (tx_buffer_empty_irq |-> $past(txOutValid && txOutReady))
    else $error("tx irq without an accepted beat");
  a_rd_data_hold: assert property (!hostRdEn |=> $stable(hostRdData))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (hostRdEn && hostAddr > 6'h25 |=> hostRdData == 8'h00)
    else $error("unmapped read not zero");
  a_ready_after_rst: assert property ($fell(rst) |-> rxInReady)
    else $error("fifo not ready after reset");

endmodule

bind hbh_buffer_handshake hbh_checker u_chk (.*);

`default_nettype wire

// ==== tb/hbh_host_model.sv ====
// Host processor model: byte reads and writes on the shared RAM port.
// Assumes the host runs on core_clk and makes one access at a time.
`default_nettype none

module hbh_host_model (
  // Clock
  input wire logic        core_clk,
  // Shared RAM port
  output var logic [5:0]  hostAddr   = 6'h00,
  output var logic        hostWrEn   = 1'b0,
  output var logic [7:0]  hostWrData = 8'h00,
  output var logic        hostRdEn   = 1'b0,
  input wire logic [7:0]  hostRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Access tasks
  // ****************************************
  // One write strobe; a strobe never spans two accesses
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hostAddr <= a;
    hostWrData <= d;
    hostWrEn <= 1'b1;
    @(posedge core_clk);
    hostWrEn <= 1'b0;
  endtask

  // Read data lands one cycle after the strobe; sample it once settled
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    hostAddr <= a;
    hostRdEn <= 1'b1;
    @(posedge core_clk);
    hostRdEn <= 1'b0;
    @(negedge core_clk);
    d = hostRdData;
  endtask

endmodule

`default_nettype wire
